// ### core/dcr_cfg.svh
// Offsets, field positions and reset values of the core control registers
`ifndef DCR_CFG_SVH
`define DCR_CFG_SVH
`define DCR_IDX_STATUS 6'h00
`define DCR_IDX_OPMODE 6'h01
`define DCR_IDX_STK_HIGH 6'h02
`define DCR_IDX_STK_LOW 6'h03
`define DCR_IDX_PROG_CNT 6'h04
`define DCR_IDX_VEC_BASE 6'h05
`define DCR_IDX_LOOP_CNT 6'h06
`define DCR_IDX_LOOP_END 6'h07
`define DCR_IDX_EXT_PTR 6'h08
`define DCR_IDX_STK_SIZE 6'h09
`define DCR_IDX_STK_CNT 6'h0A
`define DCR_IDX_STK_PTR 6'h0B
`define DCR_IDX_AREG 6'h10
`define DCR_IDX_AEND 6'h27
`define DCR_STAT_WMASK 24'hFBEFFF
`define DCR_OPM_WMASK 24'h1F9FDF
`define DCR_VEC_WMASK 24'hFFFF00
`define DCR_STAT_RESET 24'h000300
`define DCR_OPM_RESET 24'h000000
`define DCR_STAT_ROUND 21
`define DCR_STAT_COMPAT 13
`define DCR_OPM_EXT_ON 20
`define DCR_OPM_EXT_OVF 18
`define DCR_OPM_EXT_UNF 17
`define DCR_OPM_BURST 10
`define DCR_PTR_UNDERFLOW 5
`define DCR_PTR_ERROR 4
`define DCR_STK_TOP 4'hF
`define DCR_CNT_FULL 5'h10
`define DCR_BURST_LEN 3'h4
`define DCR_SINGLE_LEN 3'h1
`endif

// ### core/dcr_pkg.sv
// Types shared by the core control register block
package dcr_pkg;
    typedef logic [23:0] dcr_word_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_COMMIT = 3'b010,
        ST_DONE = 3'b100
    } dcr_bus_st_t;
endpackage : dcr_pkg

// ### core/dcr_regs.sv
// Core control and status registers with hardware stack, AHB-Lite slave
// Functional notes
// - Address pointer, offset, modifier registers 24 bits
// - Compat bit clears top eight bits
// - Status word: extended, mode, condition bytes
// - Extended mode byte field layout
// - Mode byte field layout
// - Condition code flags bits seven to zero
// - Operating mode word of three bytes
// - Stack control byte field layout
// - Extended chip mode byte field layout
// - Chip mode byte field layout
// - Sixteen entry stack, two 24-bit halves
// - Fifteen levels unless extension enabled
// - Program counter is 24 bits
// - Vector base low byte reads zero
// - Loop count is 24 bits
// - Loop end address is 24 bits
// - Extension pointer addresses stack extension; here ext_ptr_q is only stored and read back, nothing uses it as an address
// - Stack size sets extended stack words
// - Five-bit count of occupied entries
// - Stack pointer flags in non-extended mode
// - Rounding select picks twos complement
// - Burst enable fetches four words
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dcr_cfg.svh"
module dcr_regs (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Core side view
    output logic [23:0] status_word,
    output logic [23:0] operating_mode_word,
    output logic [23:0] program_counter,
    output logic [23:0] vector_base,
    output logic round_twos_sel,
    output logic [2:0] burst_fetch_len,
    output logic stack_error
);

    // Registers whose moves obey the compatibility bit
    function automatic logic is_compat(input logic [5:0] idx);
        case (idx)
            `DCR_IDX_STK_HIGH, `DCR_IDX_STK_LOW, `DCR_IDX_VEC_BASE,
            `DCR_IDX_LOOP_CNT, `DCR_IDX_LOOP_END, `DCR_IDX_EXT_PTR,
            `DCR_IDX_STK_SIZE, `DCR_IDX_STK_CNT,
            `DCR_IDX_STK_PTR: is_compat = 1'b1;
            default: is_compat = 1'b0;
        endcase
    endfunction : is_compat

    // Clear the upper byte of a move in compatibility mode
    function automatic dcr_pkg::dcr_word_t compat_fn(
        input dcr_pkg::dcr_word_t v, input logic on);
        compat_fn = on ? {8'h00, v[15:0]} : v;
    endfunction : compat_fn

    dcr_pkg::dcr_bus_st_t st_q;
    dcr_pkg::dcr_word_t stat_q, opmode_q, prog_cnt_q, vec_base_q;
    dcr_pkg::dcr_word_t loop_cnt_q, loop_end_q;
    dcr_pkg::dcr_word_t ext_ptr_q, stk_size_q, stk_ptr_q;
    dcr_pkg::dcr_word_t addr_gen_q [24];
    logic [47:0] stk_mem [16];
    logic [4:0] stk_cnt_q;
    logic [5:0] wr_idx_q;
    logic [2:0] burst_q;
    logic acc, rd_acc, wr_acc, wr_en, push, pop, stk_low_wr, compat;
    logic push_block, pop_block;
    logic [5:0] ridx;
    logic [3:0] top;
    dcr_pkg::dcr_word_t wv, rv;

    // Transfer decode; only the low six word address bits select
    assign acc = hsel && htrans[1] && hready;
    assign rd_acc = acc && !hwrite;
    assign wr_acc = acc && hwrite;
    assign ridx = haddr[7:2];
    assign wr_en = (st_q == dcr_pkg::ST_COMMIT);
    assign compat = stat_q[`DCR_STAT_COMPAT];
    assign wv = compat_fn(hwdata[23:0], compat && is_compat(wr_idx_q));
    assign top = stk_ptr_q[3:0];
    assign push = wr_en && (wr_idx_q == `DCR_IDX_STK_HIGH);
    assign stk_low_wr = wr_en && (wr_idx_q == `DCR_IDX_STK_LOW);
    assign pop = rd_acc && (ridx == `DCR_IDX_STK_HIGH);
    // Without the extension only fifteen levels nest
    assign push_block = !opmode_q[`DCR_OPM_EXT_ON]
                        && (top == `DCR_STK_TOP);
    assign pop_block = !opmode_q[`DCR_OPM_EXT_ON] && (top == 4'h0);

    // Writes take one wait state so a following read sees the new value
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= dcr_pkg::ST_IDLE;
        end else begin
            case (st_q)
                dcr_pkg::ST_IDLE, dcr_pkg::ST_DONE: begin
                    st_q <= wr_acc ? dcr_pkg::ST_COMMIT : dcr_pkg::ST_IDLE;
                end
                dcr_pkg::ST_COMMIT: st_q <= dcr_pkg::ST_DONE;
                default: st_q <= dcr_pkg::ST_IDLE;
            endcase
        end
    end

    // Write index captured in the address phase
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_idx_q <= 6'h3F;
        end else if (wr_acc) begin
            wr_idx_q <= ridx;
        end
    end

    assign hreadyout = (st_q != dcr_pkg::ST_COMMIT);
    assign hresp = 1'b0;

    // Status word; reserved bits 18 and 12 never store
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stat_q <= `DCR_STAT_RESET;
        end else if (wr_en && wr_idx_q == `DCR_IDX_STATUS) begin
            stat_q <= wv & `DCR_STAT_WMASK;
        end
    end

    // Operating mode word; hardware stack flags win over a clearing write
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            opmode_q <= `DCR_OPM_RESET;
        end else begin
            if (wr_en && wr_idx_q == `DCR_IDX_OPMODE) begin
                opmode_q <= wv & `DCR_OPM_WMASK;
            end
            if (push && opmode_q[`DCR_OPM_EXT_ON]
                && (stk_ptr_q >= stk_size_q)) begin
                opmode_q[`DCR_OPM_EXT_OVF] <= 1'b1;
            end
            if (pop && opmode_q[`DCR_OPM_EXT_ON]
                && (stk_ptr_q == 24'h000000)) begin
                opmode_q[`DCR_OPM_EXT_UNF] <= 1'b1;
            end
        end
    end

    // Plain 24-bit control registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prog_cnt_q <= 24'h000000;
            vec_base_q <= 24'h000000;
            loop_cnt_q <= 24'h000000;
            loop_end_q <= 24'h000000;
            ext_ptr_q <= 24'h000000;
            stk_size_q <= 24'h000000;
        end else if (wr_en) begin
            case (wr_idx_q)
                `DCR_IDX_PROG_CNT: prog_cnt_q <= wv;
                `DCR_IDX_VEC_BASE: vec_base_q <= wv & `DCR_VEC_WMASK;
                `DCR_IDX_LOOP_CNT: loop_cnt_q <= wv;
                `DCR_IDX_LOOP_END: loop_end_q <= wv;
                `DCR_IDX_EXT_PTR: ext_ptr_q <= wv;
                `DCR_IDX_STK_SIZE: stk_size_q <= wv;
                default: ;
            endcase
        end
    end

    // Address generator pointers, offsets and modifiers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 24; i++) begin
                addr_gen_q[i] <= 24'h000000;
            end
        end else if (wr_en && wr_idx_q >= `DCR_IDX_AREG
                     && wr_idx_q <= `DCR_IDX_AEND) begin
            addr_gen_q[5'(wr_idx_q - `DCR_IDX_AREG)] <= wv;
        end
    end

    // Stack pointer; in non-extended mode bits 5 and 4 are sticky flags
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stk_ptr_q <= 24'h000000;
        end else if (wr_en && wr_idx_q == `DCR_IDX_STK_PTR) begin
            stk_ptr_q <= wv;
        end else if (push) begin
            if (push_block) begin
                stk_ptr_q[`DCR_PTR_ERROR] <= 1'b1;
            end else begin
                stk_ptr_q <= stk_ptr_q + 24'h000001;
            end
        end else if (pop) begin
            if (pop_block) begin
                stk_ptr_q[`DCR_PTR_UNDERFLOW] <= 1'b1;
                stk_ptr_q[`DCR_PTR_ERROR] <= 1'b1;
            end else begin
                stk_ptr_q <= stk_ptr_q - 24'h000001;
            end
        end
    end

    // Occupied entry count follows pushes and pops
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stk_cnt_q <= 5'h00;
        end else if (wr_en && wr_idx_q == `DCR_IDX_STK_CNT) begin
            stk_cnt_q <= wv[4:0];
        end else if (push && !push_block && stk_cnt_q != `DCR_CNT_FULL) begin
            stk_cnt_q <= stk_cnt_q + 5'h01;
        end else if (pop && !pop_block && stk_cnt_q != 5'h00) begin
            stk_cnt_q <= stk_cnt_q - 5'h01;
        end
    end

    // Stack memory: high write pushes, low write fills the top
    always_ff @(posedge mclk) begin
        if (push && !push_block) begin
            stk_mem[top + 4'h1][47:24] <= wv;
        end else if (stk_low_wr) begin
            stk_mem[top][23:0] <= wv;
        end
    end

    // Read mux; the stack memory carries no reset, so an empty pop may
    // return unknown data until software has filled that entry
    always_comb begin
        rv = 24'h000000;
        case (ridx)
            `DCR_IDX_STATUS: rv = stat_q;
            `DCR_IDX_OPMODE: rv = opmode_q;
            `DCR_IDX_STK_HIGH: rv = stk_mem[top][47:24];
            `DCR_IDX_STK_LOW: rv = stk_mem[top][23:0];
            `DCR_IDX_PROG_CNT: rv = prog_cnt_q;
            `DCR_IDX_VEC_BASE: rv = vec_base_q;
            `DCR_IDX_LOOP_CNT: rv = loop_cnt_q;
            `DCR_IDX_LOOP_END: rv = loop_end_q;
            `DCR_IDX_EXT_PTR: rv = ext_ptr_q;
            `DCR_IDX_STK_SIZE: rv = stk_size_q;
            `DCR_IDX_STK_CNT: rv = {19'h00000, stk_cnt_q};
            `DCR_IDX_STK_PTR: rv = stk_ptr_q;
            default: begin
                if (ridx >= `DCR_IDX_AREG && ridx <= `DCR_IDX_AEND) begin
                    rv = addr_gen_q[5'(ridx - `DCR_IDX_AREG)];
                end
            end
        endcase
    end

    // Read data held through the data phase; unmapped reads give zero
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= 32'h00000000;
        end else if (rd_acc) begin
            hrdata <= {8'h00, compat_fn(rv, compat && is_compat(ridx))};
        end
    end

    // Core side control outputs; burst length lags the mode bit a cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            burst_q <= `DCR_SINGLE_LEN;
        end else begin
            burst_q <= opmode_q[`DCR_OPM_BURST] ? `DCR_BURST_LEN
                                                : `DCR_SINGLE_LEN;
        end
    end

    assign burst_fetch_len = burst_q;
    assign round_twos_sel = stat_q[`DCR_STAT_ROUND];
    assign status_word = stat_q;
    assign operating_mode_word = opmode_q;
    assign program_counter = prog_cnt_q;
    assign vector_base = vec_base_q;
    assign stack_error = stk_ptr_q[`DCR_PTR_ERROR]
                         && !opmode_q[`DCR_OPM_EXT_ON];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // Register masks, read and write paths, burst length
    a_vec_low_zero: assert property (vec_base_q[7:0] == 8'h00)
        else $error("vector base low byte not zero");
    a_stat_reserved: assert property (
        (stat_q & ~`DCR_STAT_WMASK) == 24'h000000)
        else $error("status reserved bit set");
    a_opm_reserved: assert property (
        (opmode_q & ~`DCR_OPM_WMASK) == 24'h000000)
        else $error("mode word reserved bit set");
    a_compat_read: assert property (rd_acc && compat
        && is_compat(ridx) |=> hrdata[23:16] == 8'h00)
        else $error("compat read kept upper byte");
    a_compat_write: assert property (wr_en && compat
        && wr_idx_q == `DCR_IDX_LOOP_CNT |=> loop_cnt_q[23:16] == 8'h00)
        else $error("compat write kept upper byte");
    a_full_read: assert property (rd_acc && !compat
        && ridx == `DCR_IDX_LOOP_END |=> hrdata[23:0] == $past(loop_end_q))
        else $error("loop address read altered");
    a_write_lands: assert property (wr_acc
        && ridx == `DCR_IDX_LOOP_CNT ##1 !compat
        |=> loop_cnt_q == $past(hwdata[23:0]))
        else $error("loop count write lost");
    a_round_sel: assert property (wr_acc
        && ridx == `DCR_IDX_STATUS ##1 1'b1
        |=> round_twos_sel == $past(hwdata[`DCR_STAT_ROUND]))
        else $error("rounding select not taken from write");
    a_burst_len: assert property (
        $rose(opmode_q[`DCR_OPM_BURST]) |=> burst_fetch_len == `DCR_BURST_LEN)
        else $error("burst length not four");
    a_write_wait: assert property (wr_acc |=> !hreadyout ##1 hreadyout)
        else $error("write wait state wrong");

    // Stack limits, flags and occupancy
    a_stack_limit: assert property (push && push_block
        |=> stk_ptr_q[3:0] == 4'hF && stk_ptr_q[`DCR_PTR_ERROR])
        else $error("stack passed fifteen levels");
    a_ext_overflow: assert property (push
        && opmode_q[`DCR_OPM_EXT_ON] && stk_ptr_q >= stk_size_q
        |=> opmode_q[`DCR_OPM_EXT_OVF])
        else $error("extension overflow not flagged");
    a_ext_underflow: assert property (pop
        && opmode_q[`DCR_OPM_EXT_ON] && stk_ptr_q == 24'h000000
        |=> opmode_q[`DCR_OPM_EXT_UNF])
        else $error("extension underflow not flagged");
    a_push_count: assert property (push && !push_block
        && stk_cnt_q < `DCR_CNT_FULL |=> stk_cnt_q == $past(stk_cnt_q) + 5'h01)
        else $error("count missed a push");
    a_count_limit: assert property (stk_cnt_q <= `DCR_CNT_FULL)
        else $error("entry count beyond sixteen");
    a_pop_underflow: assert property (pop && pop_block
        |=> stk_ptr_q[`DCR_PTR_UNDERFLOW] && stk_ptr_q[`DCR_PTR_ERROR])
        else $error("underflow not flagged");

    // Main scenarios the bench should reach
    c_push_pop: cover property (push ##[1:20] pop);
    c_overflow: cover property (push && push_block);
    c_compat_rd: cover property (rd_acc && compat && is_compat(ridx));
    c_ext_ovf: cover property ($rose(opmode_q[`DCR_OPM_EXT_OVF]));
    c_ext_unf: cover property ($rose(opmode_q[`DCR_OPM_EXT_UNF]));

endmodule : dcr_regs
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the core control register block over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // Byte addresses of the register map
    localparam logic [31:0] A_STAT = 32'h00;
    localparam logic [31:0] A_OPM = 32'h04;
    localparam logic [31:0] A_STKH = 32'h08;
    localparam logic [31:0] A_STKL = 32'h0C;
    localparam logic [31:0] A_VBASE = 32'h14;
    localparam logic [31:0] A_LCNT = 32'h18;
    localparam logic [31:0] A_SCNT = 32'h28;
    localparam logic [31:0] A_PTR = 32'h2C;
    localparam logic [31:0] A_AREG = 32'h40;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic [23:0] status_word;
    logic [23:0] operating_mode_word;
    logic [23:0] program_counter;
    logic [23:0] vector_base;
    logic round_twos_sel;
    logic [2:0] burst_fetch_len;
    logic stack_error;
    int errors = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic [31:0] regs24 [5] = '{32'h10, 32'h18, 32'h1C, 32'h20, 32'h24};

    // Clock at 40 MHz
    always #12.5 mclk = ~mclk;

    dcr_regs dcr_regs_i (
        .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .status_word(status_word),
        .operating_mode_word(operating_mode_word),
        .program_counter(program_counter), .vector_base(vector_base),
        .round_twos_sel(round_twos_sel), .burst_fetch_len(burst_fetch_len),
        .stack_error(stack_error)
    );

    // One compare for every kind of result, widened to a word
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Single AHB-Lite transfer; hready is waited for, never counted on
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rdat);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rdat = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] wd);
        logic [31:0] x;
        bus(1'b1, a, wd, x);
    endtask : wr

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, exp);
    endtask : rdc

    task automatic end_of_test;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        // Reset state
        rdc(A_STAT, 32'h000300);
        rdc(A_OPM, 32'h0);
        chk({29'h0, burst_fetch_len}, 32'h1);
        // Status word: reserved 18 and 12 stay zero, all else holds
        wr(A_STAT, 32'hFFFFFFFF);
        rdc(A_STAT, 32'h00FBEFFF);
        chk({8'h0, status_word}, 32'h00FBEFFF);
        chk({31'h0, round_twos_sel}, 32'h1);
        wr(A_STAT, 32'h0);
        chk({31'h0, round_twos_sel}, 32'h0);
        // Operating mode word: reserved bits 23-21, 14-13 and 5 read zero
        wr(A_OPM, 32'hFFFFFFFF);
        rdc(A_OPM, 32'h001F9FDF);
        chk({29'h0, burst_fetch_len}, 32'h4);
        chk({8'h0, operating_mode_word}, 32'h001F9FDF);
        wr(A_OPM, 32'h00000000);
        rdc(A_OPM, 32'h0);
        chk({29'h0, burst_fetch_len}, 32'h1);
        // Plain 24-bit registers keep all 24 bits, upper byte reads zero
        for (int i = 0; i < 5; i++) begin
            wr(regs24[i], {8'h5A, 24'hF0C3A5 - 24'(i)});
            rdc(regs24[i], {8'h00, 24'hF0C3A5 - 24'(i)});
        end
        chk({8'h0, program_counter}, 32'h00F0C3A5);
        for (int i = 0; i < 24; i++) begin
            wr(A_AREG + 32'(4 * i), {8'hA5, 24'h8E7D6C + 24'(i)});
            rdc(A_AREG + 32'(4 * i), {8'h00, 24'h8E7D6C + 24'(i)});
        end
        // Vector base low byte is read-only zero
        wr(A_VBASE, 32'hFFFFFFFF);
        rdc(A_VBASE, 32'h00FFFF00);
        chk({8'h0, vector_base}, 32'h00FFFF00);
        // Compatibility mode clears the top byte of the listed moves
        wr(A_STAT, 32'h00002000);
        rdc(A_LCNT, 32'h0000C3A4);
        wr(A_LCNT, 32'h00FFFFFF);
        rdc(A_LCNT, 32'h0000FFFF);
        wr(A_VBASE, 32'h00FFFFFF);
        rdc(A_VBASE, 32'h0000FF00);
        wr(A_STAT, 32'h0);
        wr(A_LCNT, 32'h00FFFFFF);
        rdc(A_LCNT, 32'h00FFFFFF);
        // Stack halves: push high, set low, read low then pop high
        wr(A_STKH, 32'h00123456);
        wr(A_STKL, 32'h00ABCDEF);
        rdc(A_STKL, 32'h00ABCDEF);
        rdc(A_STKH, 32'h00123456);
        rdc(A_PTR, 32'h0);
        rdc(A_SCNT, 32'h0);
        // Fifteen levels fit, the sixteenth push is refused with an error
        for (int i = 0; i < 15; i++) begin
            wr(A_STKH, 32'(i));
        end
        rdc(A_PTR, 32'h0F);
        rdc(A_SCNT, 32'h0F);
        chk({31'h0, stack_error}, 32'h0);
        wr(A_STKH, 32'h00777777);
        rdc(A_PTR, 32'h1F);
        chk({31'h0, stack_error}, 32'h1);
        // Pop of an empty stack flags underflow and error
        wr(A_PTR, 32'h0);
        wr(A_SCNT, 32'h0);
        chk({31'h0, stack_error}, 32'h0);
        bus(1'b0, A_STKH, 32'h0, rd);
        chk({31'h0, stack_error}, 32'h1);
        rdc(A_PTR, 32'h30);
        // Extension on: full pointer moves, size limit and empty pop flags
        wr(A_OPM, 32'h00100000);
        wr(A_PTR, 32'h0);
        wr(32'h24, 32'h1);
        wr(A_STKH, 32'h00000011);
        wr(A_STKH, 32'h00000022);
        rdc(A_PTR, 32'h02);
        rdc(A_OPM, 32'h00140000);
        wr(A_PTR, 32'h0);
        bus(1'b0, A_STKH, 32'h0, rd);
        rdc(A_OPM, 32'h00160000);
        chk({31'h0, stack_error}, 32'h0);
        // Unmapped word: write ignored, read zero
        wr(32'h3C, 32'h00FFFFFF);
        rdc(32'h3C, 32'h0);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
